// ### ppm_pkg.sv
// Summary of operation
// - Reset brings every pin up as GPIO
// - P1.4-6 sel+dir drive clock, compare 0, 1
// - P1.7 sel+dir drives compare 2
// - JTAG active overrides P1.4-7 fully
// - P2.0 aux clock; P2.2 capture0B or compare0
// - P2.1 timer clock input or subsystem clock
// - P2.3 capture1B input or compare 1 out
// - P2.4 sel+dir drives compare 2
// - Analog enable kills driver and input buffer
// - P2.5 resistor enable overrides; else sel+dir drives ground
// - P2.5 sel, dir 0: no function, undriven
package ppm_pkg;
  localparam logic [31:0] PPM_ADDR_P1_DIR = 32'h0000_0000;
  localparam logic [31:0] PPM_ADDR_P1_SEL = 32'h0000_0004;
  localparam logic [31:0] PPM_ADDR_P1_OUT = 32'h0000_0008;
  localparam logic [31:0] PPM_ADDR_P2_DIR = 32'h0000_000C;
  localparam logic [31:0] PPM_ADDR_P2_SEL = 32'h0000_0010;
  localparam logic [31:0] PPM_ADDR_P2_OUT = 32'h0000_0014;
  localparam logic [31:0] PPM_ADDR_ANALOG = 32'h0000_0018;
  localparam logic [31:0] PPM_ADDR_CTRL = 32'h0000_001C;
  localparam logic [31:0] PPM_ADDR_P1_IN = 32'h0000_0020;
  localparam logic [31:0] PPM_ADDR_P2_IN = 32'h0000_0024;
  localparam logic [7:0] PPM_RST_BYTE = 8'h00;
  localparam int PPM_CTRL_JTAG_BIT = 0;
  localparam int PPM_CTRL_ROSC_BIT = 1;
  localparam logic [1:0] PPM_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPM_RESP_SLVERR = 2'h2;
endpackage

// ### ppm_pin_logic.sv
`timescale 1ns/1ps
// Combinational routing of the ten covered pins.
module ppm_pin_logic
  import ppm_pkg::*;
(
  input wire logic [7:4] p1_dir,
  input wire logic [7:4] p1_sel,
  input wire logic [7:4] p1_out,
  input wire logic [5:0] p2_dir,
  input wire logic [5:0] p2_sel,
  input wire logic [5:0] p2_out,
  input wire logic [4:0] analog_en,
  input wire logic jtag_active,
  input wire logic osc_res_en,
  input wire logic subsystem_clock_out,
  input wire logic aux_clock_out,
  input wire logic timer1_compare_out0,
  input wire logic timer1_compare_out1,
  input wire logic timer1_compare_out2,
  input wire logic jtag_tdo,
  input wire logic jtag_tdo_en,
  input wire logic [7:4] p1_pad_in,
  input wire logic [5:0] p2_pad_in,
  output logic [7:4] p1_pad_o,
  output logic [7:4] p1_pad_oe,
  output logic [5:0] p2_pad_o,
  output logic [5:0] p2_pad_oe,
  output logic [5:0] p2_ibuf_en,
  output logic timer1_capture_in0b,
  output logic timer1_capture_in1b,
  output logic timer1_ext_clock_in,
  output logic osc_resistor_connect
);
  logic [5:0] periph_o;

  always_comb begin
    // JTAG owns the direction of P1.4-7; only TDO drives.
    if (jtag_active) begin
      p1_pad_o = {jtag_tdo, 3'h0};
      p1_pad_oe = {jtag_tdo_en, 3'h0};
    end else begin
      for (int i = 4; i < 8; i++) begin
        p1_pad_o[i] = p1_out[i];
        p1_pad_oe[i] = p1_dir[i];
      end
      if (p1_sel[4]) p1_pad_o[4] = subsystem_clock_out;
      if (p1_sel[5]) p1_pad_o[5] = timer1_compare_out0;
      if (p1_sel[6]) p1_pad_o[6] = timer1_compare_out1;
      if (p1_sel[7]) p1_pad_o[7] = timer1_compare_out2;
    end
    periph_o = {1'b0, timer1_compare_out2, timer1_compare_out1,
                timer1_compare_out0, subsystem_clock_out,
                aux_clock_out};
    for (int i = 0; i < 6; i++) begin
      p2_pad_o[i] = p2_sel[i] ? periph_o[i] : p2_out[i];
      p2_pad_oe[i] = p2_dir[i];
      p2_ibuf_en[i] = 1'b1;
    end
    for (int i = 0; i < 5; i++) begin
      if (analog_en[i]) begin
        p2_pad_oe[i] = 1'b0;
        p2_ibuf_en[i] = 1'b0;
      end
    end
    // P2.5 with select and dir 0 has no function and stays undriven.
    if (p2_sel[5] && !p2_dir[5]) p2_pad_oe[5] = 1'b0;
    if (osc_res_en) begin
      p2_pad_oe[5] = 1'b0;
      p2_ibuf_en[5] = 1'b0;
    end
    timer1_ext_clock_in = p2_sel[1] && !p2_dir[1] && !analog_en[1]
                          && p2_pad_in[1];
    timer1_capture_in0b = p2_sel[2] && !p2_dir[2] && !analog_en[2]
                          && p2_pad_in[2];
    timer1_capture_in1b = p2_sel[3] && !p2_dir[3] && !analog_en[3]
                          && p2_pad_in[3];
    osc_resistor_connect = osc_res_en;
  end
endmodule

// ### ppm_port_mux.sv
`timescale 1ns/1ps
// Pin function mux with an AXI4-Lite register slave. Pad and peripheral
// outputs are registered, so routing lags a register write by one cycle.
module ppm_port_mux
  import ppm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic subsystem_clock_out,
  input wire logic aux_clock_out,
  input wire logic timer1_compare_out0,
  input wire logic timer1_compare_out1,
  input wire logic timer1_compare_out2,
  input wire logic jtag_tdo,
  input wire logic jtag_tdo_en,
  input wire logic [7:4] p1_pad_in,
  input wire logic [5:0] p2_pad_in,
  output logic [7:4] p1_pad_o,
  output logic [7:4] p1_pad_oe,
  output logic [5:0] p2_pad_o,
  output logic [5:0] p2_pad_oe,
  output logic [5:0] p2_ibuf_en,
  output logic timer1_capture_in0b,
  output logic timer1_capture_in1b,
  output logic timer1_ext_clock_in,
  output logic osc_resistor_connect,
  output logic [7:4] jtag_pins_in
);
  logic [7:0] p1_dir_q, p1_dir_d, p1_sel_q, p1_sel_d;
  logic [7:0] p1_out_q, p1_out_d, p2_dir_q, p2_dir_d;
  logic [7:0] p2_sel_q, p2_sel_d, p2_out_q, p2_out_d;
  logic [7:0] ana_q, ana_d, ctrl_q, ctrl_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic [31:0] rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:4] p1o, p1oe, p1_pad_o_q, p1_pad_oe_q;
  logic [5:0] p2o, p2oe, p2ib, p2_pad_o_q, p2_pad_oe_q, p2_ibuf_q;
  logic ci0, ci1, eci, orc, ci0_q, ci1_q, eci_q, orc_q;
  logic [7:4] jtag_in_q, jtag_in_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] st);
    merge = st[0] ? wd[7:0] : old;
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:6] == 26'h0) && (a[1:0] == 2'h0) &&
             (a[5:2] <= 4'h9);
  endfunction

  always_comb begin
    p1_dir_d = p1_dir_q;
    p1_sel_d = p1_sel_q;
    p1_out_d = p1_out_q;
    p2_dir_d = p2_dir_q;
    p2_sel_d = p2_sel_q;
    p2_out_d = p2_out_q;
    ana_d = ana_q;
    ctrl_d = ctrl_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(awaddr_q) ? PPM_RESP_OKAY : PPM_RESP_SLVERR;
      case (awaddr_q)
        PPM_ADDR_P1_DIR: p1_dir_d = merge(p1_dir_q, wdata_q, wstrb_q);
        PPM_ADDR_P1_SEL: p1_sel_d = merge(p1_sel_q, wdata_q, wstrb_q);
        PPM_ADDR_P1_OUT: p1_out_d = merge(p1_out_q, wdata_q, wstrb_q);
        PPM_ADDR_P2_DIR: p2_dir_d = merge(p2_dir_q, wdata_q, wstrb_q);
        PPM_ADDR_P2_SEL: p2_sel_d = merge(p2_sel_q, wdata_q, wstrb_q);
        PPM_ADDR_P2_OUT: p2_out_d = merge(p2_out_q, wdata_q, wstrb_q);
        PPM_ADDR_ANALOG: ana_d = merge(ana_q, wdata_q, wstrb_q);
        PPM_ADDR_CTRL: ctrl_d = merge(ctrl_q, wdata_q, wstrb_q) & 8'h03;
        default: ;
      endcase
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(s_axi_araddr) ? PPM_RESP_OKAY : PPM_RESP_SLVERR;
      case (s_axi_araddr)
        PPM_ADDR_P1_DIR: rdata_d = {24'h0, p1_dir_q};
        PPM_ADDR_P1_SEL: rdata_d = {24'h0, p1_sel_q};
        PPM_ADDR_P1_OUT: rdata_d = {24'h0, p1_out_q};
        PPM_ADDR_P2_DIR: rdata_d = {24'h0, p2_dir_q};
        PPM_ADDR_P2_SEL: rdata_d = {24'h0, p2_sel_q};
        PPM_ADDR_P2_OUT: rdata_d = {24'h0, p2_out_q};
        PPM_ADDR_ANALOG: rdata_d = {24'h0, ana_q};
        PPM_ADDR_CTRL: rdata_d = {24'h0, ctrl_q};
        // Pin state reads zero where the input buffer is disabled.
        PPM_ADDR_P1_IN: rdata_d = {24'h0, p1_pad_in, 4'h0};
        PPM_ADDR_P2_IN: rdata_d = {26'h0, p2_pad_in & p2_ibuf_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    // Ready is registered from the next holding state, so that every bus
    // output leaves the block straight from a flop.
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    arready_d = !rvalid_d;
    // JTAG sees TCK, TMS, TDI and the pin 7 input only while active.
    jtag_in_d = ctrl_q[PPM_CTRL_JTAG_BIT] ? p1_pad_in : 4'h0;
  end

  ppm_pin_logic u_pins (
    .p1_dir(p1_dir_q[7:4]),
    .p1_sel(p1_sel_q[7:4]),
    .p1_out(p1_out_q[7:4]),
    .p2_dir(p2_dir_q[5:0]),
    .p2_sel(p2_sel_q[5:0]),
    .p2_out(p2_out_q[5:0]),
    .analog_en(ana_q[4:0]),
    .jtag_active(ctrl_q[PPM_CTRL_JTAG_BIT]),
    .osc_res_en(ctrl_q[PPM_CTRL_ROSC_BIT]),
    .subsystem_clock_out(subsystem_clock_out),
    .aux_clock_out(aux_clock_out),
    .timer1_compare_out0(timer1_compare_out0),
    .timer1_compare_out1(timer1_compare_out1),
    .timer1_compare_out2(timer1_compare_out2),
    .jtag_tdo(jtag_tdo),
    .jtag_tdo_en(jtag_tdo_en),
    .p1_pad_in(p1_pad_in),
    .p2_pad_in(p2_pad_in),
    .p1_pad_o(p1o),
    .p1_pad_oe(p1oe),
    .p2_pad_o(p2o),
    .p2_pad_oe(p2oe),
    .p2_ibuf_en(p2ib),
    .timer1_capture_in0b(ci0),
    .timer1_capture_in1b(ci1),
    .timer1_ext_clock_in(eci),
    .osc_resistor_connect(orc)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_dir_q <= PPM_RST_BYTE;
      p1_sel_q <= PPM_RST_BYTE;
      p1_out_q <= PPM_RST_BYTE;
      p2_dir_q <= PPM_RST_BYTE;
      p2_sel_q <= PPM_RST_BYTE;
      p2_out_q <= PPM_RST_BYTE;
      ana_q <= PPM_RST_BYTE;
      ctrl_q <= PPM_RST_BYTE;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rresp_q <= 2'h0;
      p1_pad_o_q <= 4'h0;
      p1_pad_oe_q <= 4'h0;
      p2_pad_o_q <= 6'h00;
      p2_pad_oe_q <= 6'h00;
      p2_ibuf_q <= 6'h3F;
      ci0_q <= 1'b0;
      ci1_q <= 1'b0;
      eci_q <= 1'b0;
      orc_q <= 1'b0;
      jtag_in_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      p1_dir_q <= p1_dir_d;
      p1_sel_q <= p1_sel_d;
      p1_out_q <= p1_out_d;
      p2_dir_q <= p2_dir_d;
      p2_sel_q <= p2_sel_d;
      p2_out_q <= p2_out_d;
      ana_q <= ana_d;
      ctrl_q <= ctrl_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      wstrb_q <= wstrb_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      p1_pad_o_q <= p1o;
      p1_pad_oe_q <= p1oe;
      p2_pad_o_q <= p2o;
      p2_pad_oe_q <= p2oe;
      p2_ibuf_q <= p2ib;
      ci0_q <= ci0;
      ci1_q <= ci1;
      eci_q <= eci;
      orc_q <= orc;
      jtag_in_q <= jtag_in_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign p1_pad_o = p1_pad_o_q;
  assign p1_pad_oe = p1_pad_oe_q;
  assign p2_pad_o = p2_pad_o_q;
  assign p2_pad_oe = p2_pad_oe_q;
  assign p2_ibuf_en = p2_ibuf_q;
  assign timer1_capture_in0b = ci0_q;
  assign timer1_capture_in1b = ci1_q;
  assign timer1_ext_clock_in = eci_q;
  assign osc_resistor_connect = orc_q;
  assign jtag_pins_in = jtag_in_q;

  a_reset_gpio: assert property (@(posedge aclk)
    !aresetn |=> (p1_sel_q == 8'h00 && ctrl_q == 8'h00 && ana_q == 8'h00))
    else $error("registers not cleared by reset");
  a_jtag_no_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[0] |=> p1_pad_oe_q[6:4] == 3'h0)
    else $error("JTAG input pin driven");
  a_analog_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ana_q[2] |=> !p2_pad_oe_q[2] && !p2_ibuf_q[2])
    else $error("analog pin driver still on");
  a_p1_clock_out: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[0] && p1_sel_q[4] && p1_dir_q[4] |=>
    p1_pad_oe_q[4] && p1_pad_o_q[4] == $past(subsystem_clock_out))
    else $error("P1.4 clock not routed");
  a_p1_cmp2: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[0] && p1_sel_q[7] && p1_dir_q[7] |=>
    p1_pad_o_q[7] == $past(timer1_compare_out2))
    else $error("P1.7 compare not routed");
  a_p2_cap0b: assert property (@(posedge aclk) disable iff (!aresetn)
    p2_sel_q[2] && !p2_dir_q[2] && !ana_q[2] |=>
    ci0_q == $past(p2_pad_in[2]))
    else $error("capture 0B not fed");
  a_p2_extclk: assert property (@(posedge aclk) disable iff (!aresetn)
    !(p2_sel_q[1] && !p2_dir_q[1]) |=> !eci_q)
    else $error("timer clock fed while not selected");
  a_p2_cap1b: assert property (@(posedge aclk) disable iff (!aresetn)
    p2_sel_q[3] && !p2_dir_q[3] && !ana_q[3] |=>
    ci1_q == $past(p2_pad_in[3]))
    else $error("capture 1B not fed");
  a_p2_cmp2: assert property (@(posedge aclk) disable iff (!aresetn)
    p2_sel_q[4] && p2_dir_q[4] && !ana_q[4] |=>
    p2_pad_oe_q[4] && p2_pad_o_q[4] == $past(timer1_compare_out2))
    else $error("P2.4 compare not routed");
  a_rosc_float: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[1] |=> orc_q && !p2_pad_oe_q[5])
    else $error("resistor pin still driven");
  a_p25_none: assert property (@(posedge aclk) disable iff (!aresetn)
    p2_sel_q[5] && !p2_dir_q[5] |=> !p2_pad_oe_q[5])
    else $error("P2.5 drives with no function");
  a_gpio_out: assert property (@(posedge aclk) disable iff (!aresetn)
    !p2_sel_q[0] && p2_dir_q[0] && !ana_q[0] |=>
    p2_pad_oe_q[0] && p2_pad_o_q[0] == $past(p2_out_q[0]))
    else $error("GPIO output not driven");
  a_jtag_tdo: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[0] |=> p1_pad_oe_q[7] == $past(jtag_tdo_en) &&
    p1_pad_o_q[7] == $past(jtag_tdo))
    else $error("JTAG data out not routed");
  a_analog_in: assert property (@(posedge aclk) disable iff (!aresetn)
    ana_q[2] |=> !ci0_q)
    else $error("analog pin still feeds capture");
endmodule

// ### ppm_pad_model.sv
`timescale 1ns/1ps
// Board side of the pads. A pad that the mux leaves undriven shows the
// external driver's level, so a stuck output enable is seen in the reads.
module ppm_pad_model (
  input wire logic [7:4] p1_o,
  input wire logic [7:4] p1_oe,
  input wire logic [5:0] p2_o,
  input wire logic [5:0] p2_oe,
  input wire logic [7:4] p1_ext,
  input wire logic [5:0] p2_ext,
  output logic [7:4] p1_in,
  output logic [5:0] p2_in
);
  assign p1_in = (p1_o & p1_oe) | (p1_ext & ~p1_oe);
  assign p2_in = (p2_o & p2_oe) | (p2_ext & ~p2_oe);
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench
  import ppm_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, tdo, tdo_en;
  logic awready, wready, bvalid, arready, rvalid, cap0, cap1, eclk, rcon;
  logic [31:0] awaddr, araddr, wdata, rdata, rd_q;
  logic [1:0] bresp, rresp, rs;
  logic [4:0] peri;
  logic [7:4] p1_in, p1_o, p1_oe, p1_ext, jpin;
  logic [5:0] p2_in, p2_o, p2_oe, p2_ext, ibuf;
  int fail_count = 0;
  int total_checks = 0;

  always #5 aclk = ~aclk;

  ppm_port_mux dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .subsystem_clock_out(peri[0]), .aux_clock_out(peri[1]),
    .timer1_compare_out0(peri[2]), .timer1_compare_out1(peri[3]),
    .timer1_compare_out2(peri[4]), .jtag_tdo(tdo), .jtag_tdo_en(tdo_en),
    .p1_pad_in(p1_in), .p2_pad_in(p2_in), .p1_pad_o(p1_o),
    .p1_pad_oe(p1_oe), .p2_pad_o(p2_o), .p2_pad_oe(p2_oe),
    .p2_ibuf_en(ibuf), .timer1_capture_in0b(cap0),
    .timer1_capture_in1b(cap1), .timer1_ext_clock_in(eclk),
    .osc_resistor_connect(rcon), .jtag_pins_in(jpin)
  );

  ppm_pad_model pad_u (
    .p1_o(p1_o), .p1_oe(p1_oe), .p2_o(p2_o), .p2_oe(p2_oe),
    .p1_ext(p1_ext), .p2_ext(p2_ext), .p1_in(p1_in), .p2_in(p2_in)
  );

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        rs = bresp;
      end
    end while ((awvalid || wvalid || bready) && n < 40);
    if (n >= 40) begin
      fail_count++;
      $display("[FAIL] write handshake expected done seen timeout");
    end
  endtask

  task automatic rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        rd_q = rdata;
        rs = rresp;
      end
    end while ((arvalid || rready) && n < 40);
    if (n >= 40) begin
      fail_count++;
      $display("[FAIL] read handshake expected done seen timeout");
    end
  endtask

  // Pad outputs are registered, so three edges cover the lag after a change.
  task automatic drive(input logic [4:0] pv, input logic [7:4] e1,
                       input logic [5:0] e2);
    @(posedge aclk);
    peri <= pv;
    p1_ext <= e1;
    p2_ext <= e2;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd(32'(i * 4));
      chk("reg reset", 8'h00, rd_q[7:0]);
    end
    rd(32'h0000_0028);
    chk("bad rresp", {6'h0, PPM_RESP_SLVERR}, {6'h0, rs});
    wr(32'h0000_002C, 8'hFF);
    chk("bad bresp", {6'h0, PPM_RESP_SLVERR}, {6'h0, rs});
    chk("p1 oe", 8'h00, {4'h0, p1_oe});
    chk("p2 oe", 8'h00, {2'h0, p2_oe});
    chk("ibuf", 8'h3F, {2'h0, ibuf});
    chk("rosc", 8'h00, {7'h0, rcon});
  endtask

  task automatic t_p1();
    logic [4:0] pv;
    wr(PPM_ADDR_P1_DIR, 8'hF0);
    chk("bresp", {6'h0, PPM_RESP_OKAY}, {6'h0, rs});
    wr(PPM_ADDR_P1_SEL, 8'hF0);
    for (int i = 0; i < 2; i++) begin
      pv = i ? 5'h0A : 5'h15;
      drive(pv, 4'h0, 6'h00);
      chk("p1 oe", 8'h0F, {4'h0, p1_oe});
      chk("p1 out", {4'h0, pv[4:2], pv[0]}, {4'h0, p1_o});
    end
  endtask

  task automatic t_jtag();
    wr(PPM_ADDR_CTRL, 8'h01);
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      tdo <= ~i[0];
      tdo_en <= ~i[0];
      drive(5'h1F, i ? 4'hA : 4'h5, 6'h00);
      chk("jtag oe", {4'h0, ~i[0], 3'h0}, {4'h0, p1_oe});
      chk("jtag in", {4'h0, i ? 4'hA : 4'hD}, {4'h0, jpin});
    end
    wr(PPM_ADDR_CTRL, 8'h00);
    drive(5'h1F, 4'h0, 6'h00);
    chk("jtag off oe", 8'h0F, {4'h0, p1_oe});
    chk("jtag off in", 8'h00, {4'h0, jpin});
  endtask

  task automatic t_p2();
    logic [4:0] pv;
    logic [5:0] e;
    wr(PPM_ADDR_P2_DIR, 8'h1F);
    wr(PPM_ADDR_P2_SEL, 8'h3F);
    for (int i = 0; i < 2; i++) begin
      pv = i ? 5'h0A : 5'h15;
      drive(pv, 4'h0, 6'h00);
      chk("p2 oe", 8'h1F, {2'h0, p2_oe});
      chk("p2 out", {3'h0, pv[4:2], pv[0], pv[1]}, {3'h0, p2_o[4:0]});
    end
    wr(PPM_ADDR_P2_DIR, 8'h00);
    for (int i = 0; i < 2; i++) begin
      e = i ? 6'h15 : 6'h2A;
      drive(5'h00, 4'h0, e);
      chk("p2 in oe", 8'h00, {2'h0, p2_oe});
      chk("capture", {5'h0, e[3:1]}, {5'h0, cap1, cap0, eclk});
    end
  endtask

  task automatic t_p25();
    wr(PPM_ADDR_P2_SEL, 8'h20);
    wr(PPM_ADDR_P2_DIR, 8'h20);
    wr(PPM_ADDR_P2_OUT, 8'h20);
    drive(5'h1F, 4'h0, 6'h3F);
    chk("gnd oe", 8'h20, {2'h0, p2_oe});
    chk("gnd out", 8'h00, {7'h0, p2_o[5]});
    wr(PPM_ADDR_CTRL, 8'h02);
    drive(5'h1F, 4'h0, 6'h3F);
    chk("rosc", 8'h01, {7'h0, rcon});
    chk("rosc oe", 8'h00, {2'h0, p2_oe});
    chk("rosc ibuf", 8'h1F, {2'h0, ibuf});
    wr(PPM_ADDR_CTRL, 8'h00);
  endtask

  task automatic t_ana();
    wr(PPM_ADDR_P2_SEL, 8'h00);
    wr(PPM_ADDR_P2_DIR, 8'h1F);
    wr(PPM_ADDR_P2_OUT, 8'h1F);
    wr(PPM_ADDR_ANALOG, 8'h0E);
    drive(5'h00, 4'h0, 6'h00);
    chk("ana oe", 8'h11, {2'h0, p2_oe});
    chk("ana ibuf", 8'h31, {2'h0, ibuf});
    wr(PPM_ADDR_ANALOG, 8'h00);
    drive(5'h00, 4'h0, 6'h00);
    chk("gpio2 out", 8'h1F, {3'h0, p2_o[4:0]});
  endtask

  task automatic t_gpio();
    wr(PPM_ADDR_P1_SEL, 8'h00);
    wr(PPM_ADDR_P1_OUT, 8'hA0);
    drive(5'h1F, 4'h9, 6'h2A);
    chk("gpio1 out", 8'h0A, {4'h0, p1_o});
    wr(PPM_ADDR_P1_DIR, 8'h00);
    wr(PPM_ADDR_P2_DIR, 8'h00);
    drive(5'h1F, 4'h9, 6'h2A);
    chk("gpio1 oe", 8'h00, {4'h0, p1_oe});
    rd(PPM_ADDR_P1_IN);
    chk("p1 in", 8'h90, rd_q[7:0]);
    rd(PPM_ADDR_P2_IN);
    chk("p2 in", 8'h2A, rd_q[7:0]);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tdo, tdo_en} = '0;
    {awaddr, araddr, wdata, peri, p1_ext, p2_ext} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_p1();
    t_jtag();
    t_p2();
    t_p25();
    t_ana();
    t_gpio();
    // A reset in mid-run must clear everything left set by the tests above.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    tally_and_finish();
  end

  initial begin
    #50000;
    fail_count++;
    $display("[FAIL] watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule
